// ==== src/lbc_bus_ctrl.sv ====
// Local bus cycle sequencer, bus hand-over and region selects.
// Assumes the core holds a request until o_core_done and the pins
// outside are resolved by the enables given here.
module lbc_bus_ctrl (
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Core side
  input wire lbc_pkg::lbc_req_s i_req,
  input wire logic i_core_boundary,
  input wire logic i_core_lock,
  input wire logic i_cfg_wr,
  input wire logic [3:0] i_cfg_idx,
  input wire lbc_pkg::lbc_region_s i_cfg,
  output logic o_core_done,
  output logic [lbc_pkg::LBC_DATA_W-1:0] o_core_rdata,
  output logic o_fault_irq,
  output logic [7:0] o_fault_vector,
  output logic o_copro_xfer_pending,
  // Bus pins
  output logic [2:0] o_cycle_status,
  output logic o_ale,
  output logic [lbc_pkg::LBC_ADDR_W-1:0] o_addr,
  output logic [lbc_pkg::LBC_DATA_W-1:0] o_data,
  output logic o_data_oe,
  input wire logic [lbc_pkg::LBC_DATA_W-1:0] i_data,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_ctl_oe,
  input wire logic i_ready,
  output logic o_xcvr_output_enable_n,
  output logic o_xcvr_direction,
  input wire logic i_lock_pin,
  output logic o_lock,
  output logic o_lock_oe,
  input wire logic i_bus_request,
  output logic o_bus_grant_out,
  output logic o_copro_select_n,
  input wire logic i_copro_xfer_request,
  input wire logic i_copro_fault_n,
  output logic o_upper_region_select_n,
  output logic o_lower_region_select_n,
  output logic [lbc_pkg::LBC_NUM_GEN-1:0] o_general_region_select_n
);

  // ************************************************************
  // Types, decode functions and state
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,  // Bus passive, waiting for core or hand-over
    ST_ADDR = 3'b001,  // Address phase, latch strobe high
    ST_DATA = 3'b010,  // Strobe asserted, first data clock
    ST_WAIT = 3'b011,  // Wait for ready
    ST_END = 3'b100,   // Strobes released, result returned
    ST_HELD = 3'b101   // Bus handed to the outside master
  } lbc_state_e;

  // Write cycles drive the data bus outward
  function automatic logic cyc_is_write(input lbc_pkg::lbc_cyc_e c);
    return (c == lbc_pkg::LBC_CYC_IOWR) || (c == lbc_pkg::LBC_CYC_MEMWR);
  endfunction

  // I/O space cycles use the I/O region decode
  function automatic logic cyc_is_io(input lbc_pkg::lbc_cyc_e c);
    return (c == lbc_pkg::LBC_CYC_IORD) || (c == lbc_pkg::LBC_CYC_IOWR);
  endfunction

  // Halt and passive codes carry no strobe and no data
  function automatic logic cyc_moves_data(input lbc_pkg::lbc_cyc_e c);
    return (c != lbc_pkg::LBC_CYC_HALT) && (c != lbc_pkg::LBC_CYC_PASV);
  endfunction

  lbc_state_e state;                          // Sequencer state
  lbc_state_e next_state;                     // Next sequencer state
  lbc_pkg::lbc_req_s cur;                     // Request being run
  lbc_pkg::lbc_region_s region [lbc_pkg::LBC_NUM_REG];  // Region table
  logic [lbc_pkg::LBC_NUM_REG-1:0] hit;       // Range hits for incoming request
  logic ignore_rdy;                           // Current cycle skips ready
  logic ready_s;                              // Synchronised ready
  logic bus_req_s;                            // Synchronised bus request
  logic fault_n_s;                            // Synchronised coprocessor fault
  logic take;                                 // Core request accepted now
  logic hand_over;                            // Bus released now
  logic rdy_ok;                               // Cycle may finish
  logic [2:0] dwell;                          // Data-phase clocks seen, saturating

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Ready is asynchronous to the core clock
  lbc_pin_sync #(.RST_VAL(1'b0)) u_sync_ready (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_pin(i_ready), .o_level(ready_s));

  // Outside master request
  lbc_pin_sync #(.RST_VAL(1'b0)) u_sync_hold (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_pin(i_bus_request),
    .o_level(bus_req_s));

  // Fault is active low; an absent coprocessor leaves it high
  lbc_pin_sync #(.RST_VAL(1'b1)) u_sync_fault (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_pin(i_copro_fault_n),
    .o_level(fault_n_s));

  // Transfer request; absent coprocessor holds it low
  lbc_pin_sync #(.RST_VAL(1'b0)) u_sync_xfer (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_pin(i_copro_xfer_request),
    .o_level(o_copro_xfer_pending)); // see RULE_13

  // ************************************************************
  // Region decode
  // ************************************************************
  // One comparator per region, fed by the request about to start
  generate
    for (genvar g = 0; g < lbc_pkg::LBC_NUM_REG; g++) begin : g_match
      lbc_range_match u_match (
        .i_region(region[g]),
        .i_addr(i_req.addr),
        .i_io(cyc_is_io(i_req.cyc)),
        .i_active(cyc_moves_data(i_req.cyc) && !i_req.copro),
        .o_hit(hit[g])
      );
    end
  endgenerate

  // Region table; only the core programming port changes it
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      region[lbc_pkg::LBC_IDX_UPPER] <= lbc_pkg::LBC_UPPER_RST; // see RULE_15
      for (int k = 1; k < lbc_pkg::LBC_NUM_REG; k++) begin
        region[k] <= lbc_pkg::LBC_OFF_RST; // see RULE_16
      end
    end else if (i_cfg_wr && (i_cfg_idx < 4'(lbc_pkg::LBC_NUM_REG))) begin
      region[i_cfg_idx] <= i_cfg;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Hand-over only at an unlocked boundary with no cycle running
  assign hand_over = (state == ST_IDLE) && bus_req_s && i_core_boundary
    && !i_core_lock && !o_lock; // see RULE_09 see RULE_06
  assign take = (state == ST_IDLE) && i_req.valid && !hand_over;
  assign rdy_ok = (ready_s && (dwell >= lbc_pkg::LBC_READY_DWELL)) || ignore_rdy; // see RULE_03

  // Data-phase dwell; a device still showing ready from the last cycle must not
  // end the next one, so ready counts only once the synchroniser can hold a level
  // driven during this cycle. Costs a few clocks on back-to-back cycles.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      dwell <= 3'h0;
    end else if ((state == ST_DATA) || (state == ST_WAIT)) begin
      if (dwell != 3'h7) begin
        dwell <= dwell + 3'h1; // see RULE_20
      end
    end else begin
      dwell <= 3'h0;
    end
  end

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (hand_over) begin
          next_state = ST_HELD;
        end else if (take) begin
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: next_state = cyc_moves_data(cur.cyc) ? ST_DATA : ST_END;
      ST_DATA: next_state = ST_WAIT;
      ST_WAIT: begin
        // Stay here, strobe held, until ready is seen
        if (rdy_ok) begin
          next_state = ST_END; // see RULE_20
        end
      end
      ST_END: next_state = ST_IDLE;
      ST_HELD: begin
        // The outside master keeps its request up for as long as it owns the bus
        if (!bus_req_s) begin
          next_state = ST_IDLE; // see RULE_08
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture the request and its ready policy when it is taken
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cur <= '0;
      ignore_rdy <= 1'b0;
    end else if (take) begin
      cur <= i_req;
      ignore_rdy <= |(hit & {region[9].ignore_ready, region[8].ignore_ready,
        region[7].ignore_ready, region[6].ignore_ready, region[5].ignore_ready,
        region[4].ignore_ready, region[3].ignore_ready, region[2].ignore_ready,
        region[1].ignore_ready, region[0].ignore_ready});
    end
  end

  // ************************************************************
  // Bus pins
  // ************************************************************
  // Status, latch strobe, address and data drive
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_cycle_status <= lbc_pkg::LBC_CYC_PASV;
      o_ale <= 1'b0;
      o_addr <= '0;
      o_data <= '0;
      o_data_oe <= 1'b0;
    end else begin
      o_ale <= (next_state == ST_ADDR); // see RULE_19
      // Status is passive outside an active cycle
      o_cycle_status <= ((next_state == ST_ADDR) || (next_state == ST_DATA)
        || (next_state == ST_WAIT)) ? (take ? i_req.cyc : cur.cyc)
        : lbc_pkg::LBC_CYC_PASV; // see RULE_18
      if (take) begin
        o_addr <= i_req.addr;
        o_data <= i_req.wdata;
      end
      // Write data leaves only in the data phase
      o_data_oe <= ((next_state == ST_DATA) || (next_state == ST_WAIT))
        && cyc_is_write(cur.cyc);
    end
  end

  // Read and write strobes, transceiver control
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_xcvr_output_enable_n <= 1'b1;
      o_xcvr_direction <= 1'b0;
    end else begin
      o_rd_n <= !(((next_state == ST_DATA) || (next_state == ST_WAIT))
        && !cyc_is_write(cur.cyc)); // see RULE_01
      o_wr_n <= !(((next_state == ST_DATA) || (next_state == ST_WAIT))
        && cyc_is_write(cur.cyc)); // see RULE_02
      o_xcvr_output_enable_n <= !((next_state == ST_DATA)
        || (next_state == ST_WAIT)); // see RULE_04
      // Direction is set in the address phase so it is settled before enable
      if (next_state == ST_ADDR) begin
        o_xcvr_direction <= cyc_is_write(i_req.cyc); // see RULE_05
      end
    end
  end

  // Lock pin: input only during reset; released to the outside master on hand-over
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_lock <= 1'b0;
      o_lock_oe <= 1'b0; // see RULE_07
      o_ctl_oe <= 1'b0;
      o_bus_grant_out <= 1'b0;
    end else begin
      o_lock <= i_core_lock && (next_state != ST_HELD);
      o_lock_oe <= (next_state != ST_HELD);
      o_ctl_oe <= (next_state != ST_HELD); // see RULE_10
      o_bus_grant_out <= (next_state == ST_HELD); // see RULE_10
    end
  end

  // ************************************************************
  // Selects
  // ************************************************************
  // Range selects follow the range hits and the coprocessor select the request, for the whole cycle; inactive otherwise
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_upper_region_select_n <= 1'b1;
      o_lower_region_select_n <= 1'b1;
      o_general_region_select_n <= '1;
      o_copro_select_n <= 1'b1;
    end else begin
      if (take) begin
        o_upper_region_select_n <= !hit[0]; // see RULE_14 see RULE_21
        o_lower_region_select_n <= !hit[1];
        o_copro_select_n <= !i_req.copro; // see RULE_11
      end else if (next_state == ST_IDLE || next_state == ST_HELD) begin
        o_upper_region_select_n <= 1'b1;
        o_lower_region_select_n <= 1'b1;
        o_copro_select_n <= 1'b1;
      end
      for (int k = 0; k < lbc_pkg::LBC_NUM_GEN; k++) begin
        // Disabled general pins are plain port outputs
        if (!region[k+2].enable) begin
          o_general_region_select_n[k] <= region[k+2].port_bit; // see RULE_17
        end else if (take) begin
          o_general_region_select_n[k] <= !hit[k+2]; // see RULE_17
        end else if (next_state == ST_IDLE || next_state == ST_HELD) begin
          o_general_region_select_n[k] <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // Core answers
  // ************************************************************
  // Data bus is sampled on the ready edge; its setup is the external device's job
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_core_done <= 1'b0;
      o_core_rdata <= '0;
      o_fault_irq <= 1'b0;
      o_fault_vector <= 8'h00;
    end else begin
      o_core_done <= (next_state == ST_END);
      if ((state == ST_WAIT) && rdy_ok) begin
        o_core_rdata <= i_data;
      end
      o_fault_irq <= take && i_req.numerics_start && !fault_n_s; // see RULE_12
      o_fault_vector <= lbc_pkg::LBC_FAULT_VECTOR;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  property p_rd_read;
    !o_rd_n |-> !cyc_is_write(cur.cyc) && (state == ST_DATA || state == ST_WAIT);
  endproperty
  a_rd_read: assert property (p_rd_read) else $error("read strobe outside read"); // see RULE_01

  property p_wr_write;
    !o_wr_n |-> cyc_is_write(cur.cyc) && !o_data_oe == 1'b0;
  endproperty
  a_wr_write: assert property (p_wr_write) else $error("write strobe bad"); // see RULE_02

  property p_wait_hold;
    (state == ST_WAIT) && !rdy_ok |=> (state == ST_WAIT) && !(o_rd_n && o_wr_n);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait not held"); // see RULE_20

  property p_ready_end;
    (state == ST_WAIT) && rdy_ok |=> (state == ST_END) ##1 o_rd_n && o_wr_n;
  endproperty
  a_ready_end: assert property (p_ready_end) else $error("cycle not ended"); // see RULE_03

  property p_ready_fresh;
    (state == ST_WAIT) && !ignore_rdy && (dwell < lbc_pkg::LBC_READY_DWELL)
      |=> (state == ST_WAIT);
  endproperty
  a_ready_fresh: assert property (p_ready_fresh) else $error("stale ready ended cycle"); // see RULE_03

  property p_den_data;
    !o_xcvr_output_enable_n |-> (state == ST_DATA || state == ST_WAIT);
  endproperty
  a_den_data: assert property (p_den_data) else $error("enable outside data"); // see RULE_04

  property p_dir;
    (state == ST_DATA) |-> (o_xcvr_direction == cyc_is_write(cur.cyc));
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong"); // see RULE_05

  property p_lock_grant;
    $past(o_lock) |-> !$rose(o_bus_grant_out);
  endproperty
  a_lock_grant: assert property (p_lock_grant) else $error("grant under lock"); // see RULE_06

  property p_grant_float;
    o_bus_grant_out |-> !o_ctl_oe && !o_data_oe && !o_lock_oe;
  endproperty
  a_grant_float: assert property (p_grant_float) else $error("grant not floated"); // see RULE_10

  property p_ale;
    $rose(o_ale) |-> (o_cycle_status == cur.cyc) ##1 !o_ale;
  endproperty
  a_ale: assert property (p_ale) else $error("latch strobe not a pulse"); // see RULE_19

  property p_fault;
    take && i_req.numerics_start && !fault_n_s |=> o_fault_irq && o_fault_vector == 8'h10;
  endproperty
  a_fault: assert property (p_fault) else $error("fault interrupt missing"); // see RULE_12

  property p_idle_sel;
    (state == ST_IDLE) && $past(state == ST_END) |-> o_upper_region_select_n
      && o_lower_region_select_n && o_copro_select_n;
  endproperty
  a_idle_sel: assert property (p_idle_sel) else $error("select left active"); // see RULE_21

  c_read: cover property ((state == ST_WAIT) && !o_rd_n ##1 state == ST_END);
  c_write_wait: cover property (!o_wr_n && !rdy_ok ##1 !o_wr_n);
  c_hand_over: cover property ($rose(o_bus_grant_out) ##[1:20] $fell(o_bus_grant_out));

endmodule // lbc_bus_ctrl

// ==== src/lbc_pkg.sv ====
// Constants, types and encodings shared by the local bus control block.
// Assumes one 100 MHz core clock and a synchronous active-high reset.
//
// Functional notes
// [RULE_01] Read strobe low during read cycles
// [RULE_02] Write strobe low during write cycles
// [RULE_03] Cycle ends on ready unless ignored
// [RULE_04] Transceiver enable only during data transfer
// [RULE_05] Direction output follows transfer direction
// [RULE_06] No bus grant while lock asserted
// [RULE_07] Lock pin weak-high input during reset
// [RULE_08] Outside master holds request while using bus
// [RULE_09] Release bus only at unlocked instruction boundary
// [RULE_10] Grant asserted, data and control floated
// [RULE_11] Coprocessor select for every coprocessor access
// [RULE_12] Fault at numerics start raises type 16
// [RULE_13] Coprocessor requests transfer; tie low otherwise
// [RULE_14] Region select active when address in range
// [RULE_15] Upper select covers top 1 KB after reset
// [RULE_16] Lower select inactive until programmed
// [RULE_17] General selects are selects or port bits
// [RULE_18] Three-bit cycle status code, passive all high
// [RULE_19] Address latch strobe pulses in address phase
// [RULE_20] Wait states hold strobe until ready
// [RULE_21] Assert only selects whose range matches
package lbc_pkg;

  // ************************************************************
  // Widths and counts
  // ************************************************************
  localparam int unsigned LBC_ADDR_W = 20;        // Memory address width
  localparam int unsigned LBC_DATA_W = 16;        // Data bus width
  localparam int unsigned LBC_NUM_GEN = 8;        // General region selects
  localparam int unsigned LBC_NUM_REG = 10;       // Upper, lower, then generals
  localparam logic [3:0] LBC_IDX_UPPER = 4'h0;    // Region index of upper select
  localparam logic [3:0] LBC_IDX_LOWER = 4'h1;    // Region index of lower select
  localparam logic [3:0] LBC_IDX_GEN0 = 4'h2;     // Region index of general 0
  localparam logic [7:0] LBC_FAULT_VECTOR = 8'h10; // Interrupt type for faults
  // Data-phase clocks before ready is trusted; covers the ready synchroniser delay
  localparam logic [2:0] LBC_READY_DWELL = 3'h5;

  // ************************************************************
  // Cycle status codes
  // ************************************************************
  typedef enum logic [2:0] {
    LBC_CYC_INTA = 3'b000,   // Interrupt acknowledge
    LBC_CYC_IORD = 3'b001,   // I/O read
    LBC_CYC_IOWR = 3'b010,   // I/O write
    LBC_CYC_HALT = 3'b011,   // Halt, no strobe
    LBC_CYC_FETCH = 3'b100,  // Instruction fetch
    LBC_CYC_MEMRD = 3'b101,  // Memory read
    LBC_CYC_MEMWR = 3'b110,  // Memory write
    LBC_CYC_PASV = 3'b111    // No bus activity
  } lbc_cyc_e;

  // ************************************************************
  // Region configuration and core request carriers
  // ************************************************************
  typedef struct packed {
    logic enable;                  // Range decode active
    logic io_space;                // Match I/O cycles instead of memory
    logic ignore_ready;            // End cycle without waiting for ready
    logic port_bit;                // Pin level when used as port output
    logic [LBC_ADDR_W-1:0] base;   // First address of range
    logic [LBC_ADDR_W-1:0] limit;  // Last address of range
  } lbc_region_s;

  typedef struct packed {
    logic valid;                   // Core wants a bus cycle
    lbc_cyc_e cyc;                 // Cycle type
    logic [LBC_ADDR_W-1:0] addr;   // Cycle address
    logic [LBC_DATA_W-1:0] wdata;  // Write data
    logic copro;                   // Access aimed at the coprocessor
    logic numerics_start;          // First access of a numerics operation
  } lbc_req_s;

  // ************************************************************
  // Reset values of the region table
  // ************************************************************
  localparam lbc_region_s LBC_UPPER_RST = '{enable: 1'b1, io_space: 1'b0,
    ignore_ready: 1'b0, port_bit: 1'b1, base: 20'hFFC00, limit: 20'hFFFFF};
  localparam lbc_region_s LBC_OFF_RST = '{enable: 1'b0, io_space: 1'b0,
    ignore_ready: 1'b0, port_bit: 1'b1, base: 20'h00000, limit: 20'h00000};

endpackage

// ==== src/lbc_pin_sync.sv ====
// Three-stage synchroniser for one asynchronous pin.
// Assumes the pin may change at any time relative to i_core_clk.
module lbc_pin_sync #(
  parameter logic RST_VAL = 1'b0  // Level shown during reset
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_pin,
  output logic o_level
);

  // ************************************************************
  // Stages
  // ************************************************************
  logic stage1;  // Read only by stage2
  logic stage2;  // Second stage
  logic stage3;  // Third stage

  // Shift chain; the output moves only when stages two and three agree
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      o_level <= RST_VAL;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        o_level <= stage3;
      end
    end
  end

endmodule // lbc_pin_sync

// ==== src/lbc_range_match.sv ====
// Combinational range compare for one region select.
// Assumes the region table is stable while a cycle is being decoded.
module lbc_range_match (
  input wire lbc_pkg::lbc_region_s i_region,
  input wire logic [lbc_pkg::LBC_ADDR_W-1:0] i_addr,
  input wire logic i_io,
  input wire logic i_active,
  output logic o_hit
);

  // ************************************************************
  // Match
  // ************************************************************
  // Hit needs an enabled region, a matching space and base <= addr <= limit
  always_comb begin
    o_hit = i_active && i_region.enable && (i_region.io_space == i_io)
      && (i_addr >= i_region.base) && (i_addr <= i_region.limit); // see RULE_14
  end

endmodule // lbc_range_match

// ==== testbench/lbc_far_model.sv ====
// Far-side memory or I/O device answering local bus cycles.
// Assumes active-low strobes and an address held through each cycle.
module lbc_far_model #(
  parameter int WAITS = 1  // Strobe cycles before ready rises
) (
  input wire logic i_core_clk,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [19:0] i_addr,
  output logic [15:0] o_data,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;  // Strobe-active cycles seen
  initial o_data = 16'h5A5A;
  initial o_ready = 1'b0;
  // ****
  // Ready and read data
  // ****
  always @(posedge i_core_clk) begin
    cnt <= (i_rd_n && i_wr_n) ? 0 : cnt + 1;
    o_ready <= !(i_rd_n && i_wr_n) && cnt >= WAITS;
    // A released bus toggles so a stale word never looks valid
    o_data <= !i_rd_n ? ~i_addr[15:0] : ~o_data;
  end
endmodule // lbc_far_model

// ==== testbench/local_bus_control_and_selects_tb.sv ====
// Self-checking bench for the bus sequencer, hand-over and selects.
// Assumes the far-side model answers every strobe with ready.
module local_bus_control_and_selects_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, cfg_wr = 1'b0, lock = 1'b0, breq = 1'b0, flt_n = 1'b1;
  logic [3:0] cfg_idx = 4'h0;
  lbc_pkg::lbc_region_s cfg = lbc_pkg::LBC_OFF_RST;
  lbc_pkg::lbc_req_s req = '0;
  logic done, irq, rd_n, wr_n, den_n, dir, grant, ctl_oe, copro_select_n, upper_region_select_n, lower_region_select_n, oe, rdy;
  logic lk, lk_oe, pend, bnd = 1'b1;  // Lock pin drive, transfer pending, core boundary
  logic [2:0] stat;
  logic [7:0] vec, gcs_n, seen;  // seen: sticky pin activity of one cycle
  logic [15:0] rdata, dout, mdata;
  logic [19:0] addr;
  int num_errors = 0, tests_run = 0;
  always #5 clk = ~clk;
  // Lock pin tied high stands for its weak pull-up
  // Coprocessor request tied low as in a system without one
  lbc_bus_ctrl lbc_bus_ctrl_inst (.i_core_clk(clk), .i_srst(srst), .i_req(req),
    .i_core_boundary(bnd), .i_core_lock(lock), .i_cfg_wr(cfg_wr), .i_cfg_idx(cfg_idx),
    .i_cfg(cfg), .o_core_done(done), .o_core_rdata(rdata), .o_fault_irq(irq),
    .o_fault_vector(vec), .o_copro_xfer_pending(pend), .o_cycle_status(stat), .o_ale(),
    .o_addr(addr), .o_data(dout), .o_data_oe(oe), .i_data(oe ? dout : mdata),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_ctl_oe(ctl_oe), .i_ready(rdy),
    .o_xcvr_output_enable_n(den_n), .o_xcvr_direction(dir), .i_lock_pin(1'b1),
    .o_lock(lk), .o_lock_oe(lk_oe), .i_bus_request(breq), .o_bus_grant_out(grant),
    .o_copro_select_n(copro_select_n), .i_copro_xfer_request(1'b0), .i_copro_fault_n(flt_n),
    .o_upper_region_select_n(upper_region_select_n), .o_lower_region_select_n(lower_region_select_n),
    .o_general_region_select_n(gcs_n));
  lbc_far_model lbc_far_model_inst (.i_core_clk(clk), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_addr(addr), .o_data(mdata), .o_ready(rdy));
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One core cycle; valid drops once done is seen so it is not taken twice
  task automatic run_cyc(input lbc_pkg::lbc_cyc_e c, input logic [19:0] a, input logic cp);
    seen = '0;
    @(posedge clk);
    req <= '{1'b1, c, a, 16'hA5C3, cp, cp};
    repeat (40) begin
      @(posedge clk);
      #1;
      seen |= {irq, !copro_select_n, !lower_region_select_n, !upper_region_select_n, !den_n && dir, !den_n, !wr_n, !rd_n};
      if (done === 1'b1) break;
    end
    if (done !== 1'b1) begin
      chk(0, 1);
      print_verdict;
    end
    req <= '0;
  endtask
  task automatic set_region(input logic [3:0] idx, input lbc_pkg::lbc_region_s r);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_idx <= idx;
    cfg <= r;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic wait_grant(input logic v);
    repeat (10) begin
      @(posedge clk);
      #1;
      if (grant === v) break;
    end
    chk(grant, v);
    if (grant !== v) print_verdict;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_read;
    run_cyc(lbc_pkg::LBC_CYC_MEMRD, 20'hFFC10, 1'b0);
    chk({seen[4:0], rdata}, {5'b10101, 16'h03EF});
  endtask
  task automatic t_write;
    set_region(lbc_pkg::LBC_IDX_LOWER, '{1'b1, 1'b0, 1'b0, 1'b1, 20'h00000, 20'h003FF});
    run_cyc(lbc_pkg::LBC_CYC_MEMWR, 20'h00100, 1'b0);
    chk(seen[5:0], 6'b101110);
    run_cyc(lbc_pkg::LBC_CYC_IORD, 20'h00100, 1'b0);
    chk(seen[5:4], 2'b00);
    run_cyc(lbc_pkg::LBC_CYC_HALT, 20'h00100, 1'b0);
    chk(seen[5:0], 6'h00);
  endtask
  task automatic t_copro;
    @(posedge clk);
    flt_n <= 1'b0;
    repeat (4) @(posedge clk);
    run_cyc(lbc_pkg::LBC_CYC_MEMRD, 20'h000F8, 1'b1);
    chk({seen[7:5], vec}, {3'b110, 8'h10});
    flt_n <= 1'b1;
  endtask
  task automatic t_port;
    set_region(lbc_pkg::LBC_IDX_GEN0, '{1'b0, 1'b0, 1'b0, 1'b0, 20'h0, 20'h0});
    repeat (2) @(posedge clk);
    #1 chk(gcs_n, 8'hFE);
  endtask
  task automatic t_hold;
    @(posedge clk);
    lock <= 1'b1;
    breq <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk({grant, lk}, 2'b01);
    @(posedge clk);
    lock <= 1'b0;
    bnd <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk(grant, 1'b0);
    @(posedge clk);
    bnd <= 1'b1;
    wait_grant(1'b1);
    chk({ctl_oe, lk_oe}, 2'b00);
    @(posedge clk);
    breq <= 1'b0;
    wait_grant(1'b0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk({pend, upper_region_select_n, lower_region_select_n, grant, stat}, 7'h37);
    t_read;
    t_write;
    t_copro;
    t_port;
    t_hold;
    t_read;
    print_verdict;
  end
endmodule // local_bus_control_and_selects_tb
